// *** core/spi_eeprom_map.svh ***
// Opcodes, frame positions, status fields and write timing of the serial EEPROM.
`ifndef SPI_EEPROM_MAP_SVH
`define SPI_EEPROM_MAP_SVH

`define OP_SET_LATCH 8'h06
`define OP_CLEAR_LATCH 8'h04
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_READ_ARRAY 8'h03
`define OP_WRITE_ARRAY 8'h02

`define BITS_OPCODE 6'h08
`define BITS_STATUS_DATA 6'h10
`define BITS_ADDR_LAST 6'h17
`define BITS_ADDR_DONE 6'h18
`define BITS_FIRST_DATA 6'h20
`define BITS_WRAP_HI 6'h27
`define BITS_WRAP_LO 6'h20

`define ST_BUSY 0
`define ST_LATCH 1
`define ST_BP_LO 2
`define ST_BP_HI 3
`define ST_PIN_EN 7

`define BP_NONE 2'h0
`define BP_QUARTER 2'h1
`define BP_HALF 2'h2

`define NV_RESET 3'h0
`define PAGE_BYTES 16
`define PAGE_IDX_W 4
`define ADDR_W_DEFAULT 10

`define CLK_HZ 20000000
`define WRITE_TIME_MS 5
`define WRITE_CYCLES ((`WRITE_TIME_MS * `CLK_HZ) / 1000)

`endif

// *** core/spi_eeprom_pkg.sv ***
// Types shared by the serial EEPROM command and protection logic.
package spi_eeprom_pkg;

	typedef struct packed {
		logic pin_en;
		logic [2:0] spare;
		logic bp_hi;
		logic bp_lo;
		logic latch;
		logic busy;
	} status_s;

endpackage

// *** core/spi_eeprom_command_protect.sv ***
// Serial EEPROM: SPI command decode, write latch, status and block protection.
`include "spi_eeprom_map.svh"
`timescale 1ns/100ps
`default_nettype none

module spi_eeprom_command_protect #(
	parameter int ADDR_W = `ADDR_W_DEFAULT,
	parameter int unsigned WRITE_CYCLES = `WRITE_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	input wire logic write_protect_n,
	input wire logic pause_n
);

	localparam int CNT_W = $clog2(WRITE_CYCLES + 1);
	localparam int PAGE_W = ADDR_W - `PAGE_IDX_W;

	generate
		if (ADDR_W < 10 || ADDR_W > 11) begin : g_bad_addr
			$error("ADDR_W must be 10 or 11");
		end
		if (WRITE_CYCLES < 1) begin : g_bad_time
			$error("WRITE_CYCLES must be at least one");
		end
		if (`PAGE_BYTES != (1 << `PAGE_IDX_W)) begin : g_bad_page
			$error("page size must match the page index width");
		end
		if (`BITS_WRAP_HI - `BITS_WRAP_LO != 6'h07) begin : g_bad_wrap
			$error("bit counter must wrap over exactly one byte");
		end
	endgenerate

	// Block protection: the pair selects how much of the top of the array is
	// locked. Pages never straddle a block boundary, so testing the page base
	// is enough for a whole page write.
	function automatic logic blocked(input logic [1:0] bp,
			input logic [ADDR_W-1:0] a);
		case (bp)
			`BP_NONE: blocked = 1'b0;
			`BP_QUARTER: blocked = (a[ADDR_W-1 -: 2] == 2'h3);
			`BP_HALF: blocked = a[ADDR_W-1];
			default: blocked = 1'b1;
		endcase
	endfunction

	// A byte boundary falls where the three low bits of the position are
	// zero; the read loader and the commit test both depend on it.
	function automatic logic on_boundary(input logic [5:0] pos);
		on_boundary = (pos[2:0] == 3'h0);
	endfunction

	// The last bit of a byte is being taken at this rising edge.
	function automatic logic byte_end(input logic [5:0] pos);
		byte_end = (pos[2:0] == 3'h7);
	endfunction

	// The protect pin matters only while the pin enable bit is set.
	function automatic logic pin_permits(input logic en,
			input logic pin_high);
		pin_permits = !en || pin_high;
	endfunction

	// Array cells; written only in the system clock domain.
	logic [7:0] mem [2**ADDR_W];

	// Link-side frame state, clocked by the serial clock, except frame_clr, which the system clock drives.
	logic frame_clr;
	logic hold_q;
	logic [5:0] bits;
	logic [7:0] op_sr;
	logic [15:0] addr_sr;
	logic [7:0] data_sr;
	logic [7:0] page_buf [`PAGE_BYTES];
	logic [`PAGE_BYTES-1:0] byte_mask;
	logic [`PAGE_IDX_W-1:0] wptr;
	logic [7:0] tx;
	logic [ADDR_W-1:0] rd_ptr;
	spi_eeprom_pkg::status_s status_m;
	spi_eeprom_pkg::status_s status_l;

	// System-side state.
	logic cs_m;
	logic cs_s;
	logic cs_d;
	logic wp_m;
	logic wp_s;
	logic latch;
	logic [1:0] bp;
	logic pin_en;
	logic [CNT_W-1:0] busy_cnt;
	spi_eeprom_pkg::status_s protection_and_progress_status;

	// Bit counter. It restarts from zero only when the system side has taken
	// the previous frame, so the frame stays readable after select rises.
	always_ff @(posedge sck or posedge frame_clr) begin
		if (frame_clr) begin
			bits <= 6'h00;
		end else if (!hold_q) begin
			if (bits == `BITS_WRAP_HI) begin
				bits <= `BITS_WRAP_LO;
			end else begin
				bits <= bits + 6'h01;
			end
		end
	end

	logic in_op;
	logic in_addr;

	// Frame phase, decoded once from the bit position.
	always_comb begin
		in_op = (bits < `BITS_OPCODE);
		in_addr = !in_op && (bits < `BITS_ADDR_DONE);
	end

	// Opcode, address and data shift in on the rising edge.
	always_ff @(posedge sck) begin
		if (!hold_q) begin
			if (in_op) begin
				op_sr <= {op_sr[6:0], si};
			end else if (in_addr) begin
				addr_sr <= {addr_sr[14:0], si};
			end else begin
				data_sr <= {data_sr[6:0], si};
			end
		end
	end

	// Page buffer: bytes land at the low address bits and wrap in the page.
	always_ff @(posedge sck) begin
		if (!hold_q && op_sr == `OP_WRITE_ARRAY) begin
			if (bits == `BITS_ADDR_LAST) begin
				wptr <= {addr_sr[2:0], si};
				byte_mask <= '0;
			// The mask marks which page bytes this frame supplied; bytes
			// that were not sent keep their old contents in the array.
			end else if (!in_op && !in_addr && byte_end(bits)) begin
				page_buf[wptr] <= {data_sr[6:0], si};
				byte_mask[wptr] <= 1'b1;
				wptr <= wptr + 4'h1;
			end
		end
	end

	// Status seen from the link side passes two flip-flops.
	always_ff @(negedge sck) begin
		status_m <= protection_and_progress_status;
		status_l <= status_m;
	end

	logic sending;
	logic load;
	logic step;
	logic [5:0] last_bits;
	logic [ADDR_W-1:0] src_addr;
	logic [7:0] next_tx;

	// Position seen at the last falling edge that was not paused. The
	// output moves only when a rising edge was counted since then, so a
	// clock pulse given while paused neither reloads a byte, which would
	// skip an address, nor drops a bit on resume.
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			last_bits <= 6'h3F;
		end else if (pause_n) begin
			last_bits <= bits;
		end
	end

	always_comb begin
		sending = 1'b0;
		step = (bits != last_bits);
		if (op_sr == `OP_READ_STATUS && bits >= `BITS_OPCODE) begin
			sending = 1'b1;
		end else if (op_sr == `OP_READ_ARRAY && bits >= `BITS_ADDR_DONE) begin
			sending = !status_l.busy;
		end
		load = sending && step && on_boundary(bits);
	end

	// Byte source: the sent address for the first byte, then the pointer.
	always_comb begin
		if (bits == `BITS_ADDR_DONE) begin
			src_addr = addr_sr[ADDR_W-1:0];
		end else begin
			src_addr = rd_ptr;
		end
		if (op_sr == `OP_READ_STATUS) begin
			next_tx = status_l;
		end else begin
			// The array is static while a read streams, since programming
			// cannot start while selected; reading it here is safe.
			next_tx = mem[src_addr];
		end
	end

	always_ff @(negedge sck) begin
		if (pause_n && load) begin
			tx <= next_tx;
			rd_ptr <= ADDR_W'(src_addr + 1'b1);
		end else if (pause_n && step) begin
			tx <= {tx[6:0], 1'b0};
		end
	end

	// Output pins change on the falling edge and let go as soon as the
	// device is deselected, without waiting for a clock.
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			so <= 1'b0;
			so_oe <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			hold_q <= !pause_n;
			so_oe <= sending && pause_n;
			if (pause_n && load) begin
				so <= next_tx[7];
			end else if (pause_n && step) begin
				so <= tx[6];
			end
		end
	end

	// Select and protect pin are synchronised before use.
	// The third select flop only gives the edge detector its previous value.
	always_ff @(posedge clk) begin
		cs_m <= cs_n;
		cs_s <= cs_m;
		cs_d <= cs_s;
		wp_m <= write_protect_n;
		wp_s <= wp_m;
	end

	logic cs_rise;
	logic busy;
	logic done;
	logic set_cmd;
	logic clr_cmd;
	logic status_ok;
	logic array_ok;
	logic [PAGE_W-1:0] page;

	// Frame fields are read only after select is seen high; the serial
	// clock is then still, so they hold steady for the decision.
	always_comb begin
		cs_rise = cs_s && !cs_d;
		busy = (busy_cnt != '0);
		done = (busy_cnt == CNT_W'(1));
		page = addr_sr[ADDR_W-1:`PAGE_IDX_W];
	end

	// Command decisions, each tied to the frame length it needs; an array write takes one or more whole data bytes.
	always_comb begin
		set_cmd = (op_sr == `OP_SET_LATCH) && (bits == `BITS_OPCODE);
		clr_cmd = (op_sr == `OP_CLEAR_LATCH) && (bits == `BITS_OPCODE);
		status_ok = (op_sr == `OP_WRITE_STATUS) &&
			(bits == `BITS_STATUS_DATA) && latch && !busy &&
			pin_permits(pin_en, wp_s);
		array_ok = (op_sr == `OP_WRITE_ARRAY) &&
			(bits >= `BITS_FIRST_DATA) && on_boundary(bits) &&
			latch && !busy &&
			!blocked(bp, {page, `PAGE_IDX_W'(0)});
	end

	// The frame is cleared one cycle after the decision. A master must keep
	// select high long enough for this, or the first bits of its next frame
	// would be lost to the clear.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frame_clr <= 1'b1;
		end else begin
			frame_clr <= cs_rise;
		end
	end

	// Write latch; a set arriving with a completing cycle wins.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			latch <= 1'b0;
		end else if (cs_rise && set_cmd) begin
			latch <= 1'b1;
		end else if ((cs_rise && clr_cmd) || done) begin
			latch <= 1'b0;
		end
	end

	// Self-timed cycle; once loaded it ignores select and the protect pin.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_cnt <= '0;
		end else if (cs_rise && (status_ok || array_ok)) begin
			busy_cnt <= CNT_W'(WRITE_CYCLES);
		end else if (busy) begin
			busy_cnt <= busy_cnt - CNT_W'(1);
		end
	end

	// Retained protection bits; only a permitted status write moves them.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{pin_en, bp} <= `NV_RESET;
		end else if (cs_rise && status_ok) begin
			pin_en <= addr_sr[`ST_PIN_EN];
			bp <= {addr_sr[`ST_BP_HI], addr_sr[`ST_BP_LO]};
		end
	end

	// The page is committed at once; reads stay refused until busy drops.
	always_ff @(posedge clk) begin
		if (cs_rise && array_ok) begin
			for (int i = 0; i < `PAGE_BYTES; i++) begin
				if (byte_mask[i]) begin
					mem[{page, `PAGE_IDX_W'(i)}] <= page_buf[i];
				end
			end
		end
	end

	// The status byte is rebuilt every cycle from the live state; the link
	// side takes it through its own two flops, so it lags a little.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			protection_and_progress_status <= '0;
		end else begin
			protection_and_progress_status.pin_en <= pin_en;
			protection_and_progress_status.spare <= 3'h0;
			protection_and_progress_status.bp_hi <= bp[1];
			protection_and_progress_status.bp_lo <= bp[0];
			protection_and_progress_status.latch <= latch;
			protection_and_progress_status.busy <= busy;
		end
	end

endmodule

`default_nettype wire

// *** sim/spi_eeprom_checker.sv ***
// Port-level assertions for the serial EEPROM command block.
`timescale 1ns/100ps
`default_nettype none
module spi_eeprom_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	input wire logic so,
	input wire logic so_oe,
	input wire logic write_protect_n,
	input wire logic pause_n
);
	logic [8:0] cnt;
	logic [7:0] op;
	// A pause shifts this count, so pauses only come after it stops mattering.
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			cnt <= 9'h000;
		end else begin
			cnt <= cnt + 9'h001;
		end
	end
	always_ff @(posedge sck) begin
		if (cnt < 9'h008) begin
			op <= {op[6:0], si};
		end
	end
	property p_sck(a, c);
		@(posedge sck) disable iff (cs_n || !rst_n) a |-> c;
	endproperty
	AST_DESEL_OE: assert property (@(posedge clk) disable iff (!rst_n)
		cs_n |-> !so_oe) else $error("oe while deselected");
	AST_DESEL_SO: assert property (@(posedge clk) disable iff (!rst_n)
		cs_n |-> !so) else $error("so while deselected");
	AST_OPCODE_QUIET: assert property (p_sck(cnt < 9'h008, !so_oe))
		else $error("oe during opcode");
	AST_ADDR_QUIET: assert property (
		p_sck(op == 8'h03 && cnt < 9'h018, !so_oe)) else $error("oe early");
	AST_NO_REPLY: assert property (p_sck(cnt > 9'h007 &&
		op != 8'h03 && op != 8'h05, !so_oe)) else $error("oe no reply");
	AST_STATUS_DRIVE: assert property (
		p_sck(op == 8'h05 && cnt > 9'h007 && pause_n, so_oe))
		else $error("status not driven");
	AST_STATUS_SPARE: assert property (p_sck(op == 8'h05 &&
		cnt > 9'h007 && cnt[2:0] inside {3'h1, 3'h2, 3'h3}, !so))
		else $error("spare bit set");
	AST_PAUSE_QUIET: assert property (
		@(negedge sck) disable iff (cs_n || !rst_n) !pause_n |=> !so_oe)
		else $error("oe while paused");
	cover property (@(posedge sck) op == 8'h05 && cnt == 9'h00F);
	cover property (@(posedge sck) op == 8'h03 && cnt == 9'h018 && so_oe);
	cover property (@(negedge sck) !pause_n && !cs_n);
endmodule
bind spi_eeprom_command_protect spi_eeprom_checker spi_eeprom_checker_inst (
	.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n), .si(si), .so(so),
	.so_oe(so_oe), .write_protect_n(write_protect_n), .pause_n(pause_n));
`default_nettype wire

// *** sim/spi_host.sv ***
// Behavioural SPI bus master that frames commands for the EEPROM block.
`timescale 1ns/100ps
`default_nettype none
module spi_host (
	output logic sck,
	output logic cs_n,
	output logic si,
	input wire logic so,
	input wire logic so_oe
);
	logic seen_oe;
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
		seen_oe = 1'b0;
	end
	// The first edge waits until the select has crossed into the clk domain.
	task automatic open_frame();
		cs_n = 1'b0;
		seen_oe = 1'b0;
		#200;
	endtask
	task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			si = b[i];
			#6 sck = 1'b1;
			// An undriven line reads as the inverse of the last level.
			r[i] = so_oe ? so : ~so;
			seen_oe = seen_oe | so_oe;
			#6 sck = 1'b0;
		end
	endtask
	task automatic pulse();
		#6 sck = 1'b1;
		#6 sck = 1'b0;
	endtask
	task automatic close_frame();
		#6 cs_n = 1'b1;
		si = ~si;
		#500;
	endtask
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the serial EEPROM command and protection block.
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic write_protect_n = 1'b1;
	logic pause_n = 1'b1;
	logic sck;
	logic cs_n;
	logic si;
	logic so;
	logic so_oe;
	logic [7:0] r;
	int n_fail = 0;
	int checks = 0;
	always #25 clk = ~clk;
	spi_host spi_host_inst (.sck(sck), .cs_n(cs_n), .si(si), .so(so),
		.so_oe(so_oe));
	// A short write time keeps the run brief; the 3200 ns waits cover it.
	spi_eeprom_command_protect #(.ADDR_W(10), .WRITE_CYCLES(60))
		spi_eeprom_command_protect_inst (.clk(clk), .rst_n(rst_n),
		.sck(sck), .cs_n(cs_n), .si(si), .so(so), .so_oe(so_oe),
		.write_protect_n(write_protect_n), .pause_n(pause_n));
	task automatic compare(input string what, input logic [7:0] exp,
		input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask
	task automatic send(input logic [7:0] q[$], input bit keep = 1'b0);
		spi_host_inst.open_frame();
		foreach (q[i]) begin
			spi_host_inst.xbyte(q[i], r);
		end
		if (!keep) begin
			spi_host_inst.close_frame();
		end
	endtask
	task automatic stat(input logic [7:0] exp);
		send('{8'h05, 8'h00});
		compare("status", exp, r);
	endtask
	task automatic rd(input logic [15:0] a, input logic [7:0] exp,
		input bit keep = 1'b0);
		send('{8'h03, a[15:8], a[7:0], 8'h00}, keep);
		compare("read", exp, r);
	endtask
	task automatic wrst(input logic [7:0] v);
		send('{8'h06});
		send('{8'h01, v});
		#3200;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d0, d1);
		send('{8'h06});
		send('{8'h02, a[15:8], a[7:0], d0, d1});
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		#400000;
		$display("ERROR run expected end seen hang");
		n_fail++;
		complete_run();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		stat(8'h00);
		send('{8'h06});
		stat(8'h02);
		send('{8'hA5, 8'h04});
		stat(8'h02);
		send('{8'h04});
		stat(8'h00);
		send('{8'h06, 8'h00});
		stat(8'h00);
		$display("test latch commands done");
		wrst(8'hFC);
		stat(8'h8C);
		@(posedge clk) write_protect_n <= 1'b0;
		wrst(8'h00);
		stat(8'h8E);
		@(posedge clk) write_protect_n <= 1'b1;
		send('{8'h01, 8'h00});
		#3200;
		stat(8'h00);
		$display("test status write done");
		wr(16'hFFFF, 8'h11, 8'h22);
		send('{8'h03, 8'h03, 8'hF0, 8'h00});
		compare("busy oe", 8'h00, {7'h00, spi_host_inst.seen_oe});
		stat(8'h03);
		#3200;
		stat(8'h00);
		rd(16'hFFFF, 8'h11);
		rd(16'h03F0, 8'h22);
		$display("test array write done");
		wrst(8'h04);
		wr(16'h03FF, 8'h33, 8'h44);
		#3200;
		stat(8'h06);
		rd(16'h03FF, 8'h11, 1'b1);
		@(posedge clk) pause_n <= 1'b0;
		spi_host_inst.pulse();
		@(posedge clk) pause_n <= 1'b1;
		compare("paused oe", 8'h00, {7'h00, so_oe});
		spi_host_inst.close_frame();
		$display("test protection and pause done");
		wr(16'h0000, 8'h5A, 8'h6B);
		#3200;
		send('{8'h06});
		send('{8'h02, 8'h00, 8'h00, 8'hC3}, 1'b1);
		spi_host_inst.pulse();
		spi_host_inst.close_frame();
		stat(8'h06);
		rd(16'h0000, 8'h5A);
		send('{8'h03, 8'h03, 8'hFF, 8'h00, 8'h00});
		compare("wrap read", 8'h5A, r);
		wrst(8'h08);
		wr(16'h0200, 8'h77, 8'h88);
		#3200;
		stat(8'h0A);
		wr(16'h01F0, 8'h77, 8'h88);
		#3200;
		rd(16'h01F1, 8'h88);
		$display("test abort wrap and half protection done");
		complete_run();
	end
endmodule
`default_nettype wire
